/* pkg/ppsd_pkg.sv */
package ppsd_pkg;
    // ************************************************************
    // widths of the shared pin groups
    // ************************************************************
    localparam int PORT_W = 16;
    localparam int HOST_W = 8;
    localparam int SER2_W = 3;
    localparam int SER1_W = 3;
    localparam int EIRQ_W = 4;
    localparam int PCI_GP_W = 7;
    localparam int DED_W = 2;
    localparam int STRAP_W = 3;

    // ************************************************************
    // port pin positions
    // ************************************************************
    localparam int PIN_DIV4 = 1;
    localparam int PIN_DIV6 = 2;
    localparam int PIN_EIRQ_LO = 4;
    localparam int PIN_EIRQ_HI = 7;
    localparam int PIN_CLKS = 8;
    localparam int PIN_PCI_LO = 9;
    localparam int PIN_PCI_HI = 15;

    // ************************************************************
    // strap bit positions and reset values
    // ************************************************************
    localparam int STRAP_PCI = 0;
    localparam int STRAP_CELL = 1;
    localparam int STRAP_SER2 = 2;
    localparam logic [STRAP_W-1:0] STRAP_RST = 3'h0;
    localparam logic OE_N_RST = 1'b1;
    localparam logic DATA_RST = 1'b0;
    localparam logic [1:0] FILL_WAIT = 2'h3;
    localparam logic [1:0] FILL_RST = 2'h0;

    typedef enum logic [2:0] {
        ST_FILL = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN = 3'b100
    } ppsd_state_e;
endpackage

/* rtl/ppsd_sync.sv */
`timescale 1ns/1ns
module ppsd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] stable
);
    import ppsd_pkg::*;

    // ************************************************************
    // three stage synchroniser, change taken when stages agree
    // ************************************************************
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic held;
        assign stable[b] = held;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                s1 <= DATA_RST;
                s2 <= DATA_RST;
                s3 <= DATA_RST;
                held <= DATA_RST;
            end else begin
                s1 <= async[b];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    held <= s3;
                end
            end
        end
    end
endmodule // ppsd_sync

/* rtl/ppsd_pin_sharing.sv */
`timescale 1ns/1ns
// Behaviour
// - divided clock pins carry clocks until pin enable and direction set.
// - four interrupt pins default to interrupt input or input-only port.
// - pci-shared port pins come out of reset with no function.
// - host pins default host port; dedicated host port without pci.
// - pci pins default host, serial two, none; two pci pins unshared.
// - serial two and serial one pins default to serial functions.
// - cell pins default serial one; serial one only without cell.
// - serial two clock source pin becomes port pin eight when set.
// - peripheral selection captured at reset and held afterwards.
module ppsd_pin_sharing #(
    parameter logic HAS_PCI = 1'b1,
    parameter logic HAS_CELL = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ppsd_pkg::STRAP_W-1:0] strapPins,
    input wire logic [ppsd_pkg::PORT_W-1:0] portPinEnableBit,
    input wire logic [ppsd_pkg::PORT_W-1:0] portPinDirectionBit,
    input wire logic [ppsd_pkg::PORT_W-1:0] portPinOut,
    output logic [ppsd_pkg::PORT_W-1:0] portPinIn,
    input wire logic [ppsd_pkg::PORT_W-1:0] portPadIn,
    output logic [ppsd_pkg::PORT_W-1:0] portPadOut,
    output logic [ppsd_pkg::PORT_W-1:0] portPadOe_n,
    input wire logic clockOutDivFour,
    input wire logic clockOutDivSix,
    output logic serial2ExtClockSource,
    output logic [ppsd_pkg::EIRQ_W-1:0] externalInterruptInputs,
    input wire logic [ppsd_pkg::PCI_GP_W-1:0] pciPortEnable,
    input wire logic [ppsd_pkg::PCI_GP_W-1:0] pciPortOut,
    input wire logic [ppsd_pkg::PCI_GP_W-1:0] pciPortDrive,
    output logic [ppsd_pkg::PCI_GP_W-1:0] pciPortIn,
    input wire logic [ppsd_pkg::HOST_W-1:0] hostPortOut,
    input wire logic hostPortDrive,
    output logic [ppsd_pkg::HOST_W-1:0] hostPortIn,
    input wire logic [ppsd_pkg::HOST_W-1:0] pciHostOut,
    input wire logic pciHostDrive,
    output logic [ppsd_pkg::HOST_W-1:0] pciHostIn,
    input wire logic [ppsd_pkg::HOST_W-1:0] hostPadIn,
    output logic [ppsd_pkg::HOST_W-1:0] hostPadOut,
    output logic [ppsd_pkg::HOST_W-1:0] hostPadOe_n,
    input wire logic [ppsd_pkg::SER2_W-1:0] serialPortTwoOut,
    input wire logic [ppsd_pkg::SER2_W-1:0] serialPortTwoDrive,
    output logic [ppsd_pkg::SER2_W-1:0] serialPortTwoIn,
    input wire logic [ppsd_pkg::SER2_W-1:0] pciSerOut,
    input wire logic [ppsd_pkg::SER2_W-1:0] pciSerDrive,
    output logic [ppsd_pkg::SER2_W-1:0] pciSerIn,
    input wire logic [ppsd_pkg::SER2_W-1:0] ser2PadIn,
    output logic [ppsd_pkg::SER2_W-1:0] ser2PadOut,
    output logic [ppsd_pkg::SER2_W-1:0] ser2PadOe_n,
    input wire logic [ppsd_pkg::SER1_W-1:0] serialPortOneOut,
    input wire logic [ppsd_pkg::SER1_W-1:0] serialPortOneDrive,
    output logic [ppsd_pkg::SER1_W-1:0] serialPortOneIn,
    input wire logic [ppsd_pkg::SER1_W-1:0] cellInterfaceOut,
    input wire logic [ppsd_pkg::SER1_W-1:0] cellInterfaceDrive,
    output logic [ppsd_pkg::SER1_W-1:0] cellInterfaceIn,
    input wire logic [ppsd_pkg::SER1_W-1:0] ser1PadIn,
    output logic [ppsd_pkg::SER1_W-1:0] ser1PadOut,
    output logic [ppsd_pkg::SER1_W-1:0] ser1PadOe_n,
    input wire logic [ppsd_pkg::DED_W-1:0] pciDedOut,
    input wire logic [ppsd_pkg::DED_W-1:0] pciDedDrive,
    output logic [ppsd_pkg::DED_W-1:0] pciDedIn,
    input wire logic [ppsd_pkg::DED_W-1:0] dedPadIn,
    output logic [ppsd_pkg::DED_W-1:0] dedPadOut,
    output logic [ppsd_pkg::DED_W-1:0] dedPadOe_n,
    output logic [ppsd_pkg::STRAP_W-1:0] selection
);
    import ppsd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ************************************************************
    // selection capture
    // ************************************************************
    logic [STRAP_W-1:0] strapStable;
    ppsd_state_e state;
    logic [1:0] fillCount;
    ppsd_sync #(.WIDTH(STRAP_W)) u_strap_sync (
        .clk(clk),
        .rstn(rstn),
        .async(strapPins),
        .stable(strapStable)
    );
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_FILL;
            fillCount <= FILL_RST;
        end else begin
            case (state)
                ST_FILL: begin
                    fillCount <= fillCount + 2'h1;
                    if (fillCount == FILL_WAIT) begin
                        state <= ST_LATCH;
                    end
                end
                ST_LATCH: state <= ST_RUN;
                ST_RUN: state <= ST_RUN;
                default: state <= ST_FILL;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selection <= STRAP_RST;
        end else if (state == ST_LATCH) begin
            selection <= strapStable;
        end
    end
    logic pciActive;
    logic cellActive;
    logic serToPci;
    assign pciActive = HAS_PCI & selection[STRAP_PCI];
    assign cellActive = HAS_CELL & selection[STRAP_CELL];
    assign serToPci = pciActive & ~selection[STRAP_SER2];
    // ************************************************************
    // port pins
    // ************************************************************
    logic [PORT_W-1:0] nextPadOut;
    logic [PORT_W-1:0] nextPadOe_n;
    logic [PORT_W-1:0] nextGpIn;
    logic [PCI_GP_W-1:0] nextPciIn;
    logic [PORT_W-1:0] gpDrive;
    assign gpDrive = portPinEnableBit & portPinDirectionBit;
    for (genvar i = 0; i < PORT_W; i++) begin : g_port
        if (i == PIN_DIV4 || i == PIN_DIV6) begin : g_clk
            logic clkSrc;
            assign clkSrc = (i == PIN_DIV4) ? clockOutDivFour : clockOutDivSix;
            assign nextPadOut[i] = gpDrive[i] ? portPinOut[i] : clkSrc;
            assign nextPadOe_n[i] = 1'b0;
            assign nextGpIn[i] = gpDrive[i] & portPadIn[i];
        end else if (i >= PIN_EIRQ_LO && i <= PIN_EIRQ_HI) begin : g_irq
            assign nextPadOut[i] = portPinOut[i];
            assign nextPadOe_n[i] = ~gpDrive[i];
            assign nextGpIn[i] = portPadIn[i];
        end else if (i == PIN_CLKS) begin : g_cks
            assign nextPadOut[i] = portPinOut[i];
            assign nextPadOe_n[i] = ~gpDrive[i];
            assign nextGpIn[i] = gpDrive[i] & portPadIn[i];
        end else if (i >= PIN_PCI_LO && HAS_PCI) begin : g_pci
            logic pciOwn;
            logic gpOwn;
            assign pciOwn = pciActive & pciPortEnable[i-PIN_PCI_LO];
            assign gpOwn = ~pciOwn & portPinEnableBit[i];
            assign nextPadOut[i] = pciOwn ? pciPortOut[i-PIN_PCI_LO]
                                          : portPinOut[i];
            // neither owner selected: driver off, input dropped
            assign nextPadOe_n[i] = pciOwn ? ~pciPortDrive[i-PIN_PCI_LO]
                                           : ~(gpOwn & gpDrive[i]);
            assign nextGpIn[i] = gpOwn & portPadIn[i];
            assign nextPciIn[i-PIN_PCI_LO] = pciOwn & portPadIn[i];
        end else begin : g_plain
            assign nextPadOut[i] = portPinOut[i];
            assign nextPadOe_n[i] = ~gpDrive[i];
            assign nextGpIn[i] = portPadIn[i];
            if (i >= PIN_PCI_LO) begin : g_nopci
                assign nextPciIn[i-PIN_PCI_LO] = 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            portPadOut <= {PORT_W{DATA_RST}};
            portPadOe_n <= {PORT_W{OE_N_RST}};
            portPinIn <= {PORT_W{DATA_RST}};
            pciPortIn <= {PCI_GP_W{DATA_RST}};
            serial2ExtClockSource <= DATA_RST;
        end else begin
            portPadOut <= nextPadOut;
            portPadOe_n <= nextPadOe_n;
            portPinIn <= nextGpIn;
            pciPortIn <= nextPciIn;
            serial2ExtClockSource <= ~gpDrive[PIN_CLKS]
                                     & portPadIn[PIN_CLKS];
        end
    end
    // ************************************************************
    // external interrupt inputs
    // ************************************************************
    ppsd_sync #(.WIDTH(EIRQ_W)) u_irq_sync (
        .clk(clk),
        .rstn(rstn),
        .async(portPadIn[PIN_EIRQ_HI:PIN_EIRQ_LO]),
        .stable(externalInterruptInputs)
    );
    // ************************************************************
    // host, serial and dedicated pci pins
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hostPadOut <= {HOST_W{DATA_RST}};
            hostPadOe_n <= {HOST_W{OE_N_RST}};
            hostPortIn <= {HOST_W{DATA_RST}};
            pciHostIn <= {HOST_W{DATA_RST}};
        end else if (pciActive) begin
            hostPadOut <= pciHostOut;
            hostPadOe_n <= {HOST_W{~pciHostDrive}};
            hostPortIn <= {HOST_W{DATA_RST}};
            pciHostIn <= hostPadIn;
        end else begin
            hostPadOut <= hostPortOut;
            hostPadOe_n <= {HOST_W{~hostPortDrive}};
            hostPortIn <= hostPadIn;
            pciHostIn <= {HOST_W{DATA_RST}};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ser2PadOut <= {SER2_W{DATA_RST}};
            ser2PadOe_n <= {SER2_W{OE_N_RST}};
            serialPortTwoIn <= {SER2_W{DATA_RST}};
            pciSerIn <= {SER2_W{DATA_RST}};
        end else if (serToPci) begin
            ser2PadOut <= pciSerOut;
            ser2PadOe_n <= ~pciSerDrive;
            serialPortTwoIn <= {SER2_W{DATA_RST}};
            pciSerIn <= ser2PadIn;
        end else begin
            ser2PadOut <= serialPortTwoOut;
            ser2PadOe_n <= ~serialPortTwoDrive;
            serialPortTwoIn <= ser2PadIn;
            pciSerIn <= {SER2_W{DATA_RST}};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ser1PadOut <= {SER1_W{DATA_RST}};
            ser1PadOe_n <= {SER1_W{OE_N_RST}};
            serialPortOneIn <= {SER1_W{DATA_RST}};
            cellInterfaceIn <= {SER1_W{DATA_RST}};
        end else if (cellActive) begin
            ser1PadOut <= cellInterfaceOut;
            ser1PadOe_n <= ~cellInterfaceDrive;
            serialPortOneIn <= {SER1_W{DATA_RST}};
            cellInterfaceIn <= ser1PadIn;
        end else begin
            ser1PadOut <= serialPortOneOut;
            ser1PadOe_n <= ~serialPortOneDrive;
            serialPortOneIn <= ser1PadIn;
            cellInterfaceIn <= {SER1_W{DATA_RST}};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dedPadOut <= {DED_W{DATA_RST}};
            dedPadOe_n <= {DED_W{OE_N_RST}};
            pciDedIn <= {DED_W{DATA_RST}};
        end else begin
            dedPadOut <= pciDedOut;
            dedPadOe_n <= ~(pciDedDrive & {DED_W{pciActive}});
            pciDedIn <= dedPadIn & {DED_W{pciActive}};
        end
    end
    // ************************************************************
    // checks
    // ************************************************************
    sequence s_latch_then_run;
        (state == ST_LATCH) ##1 (state == ST_RUN) [*2];
    endsequence
    chk_clock_out_default: assert property (
        !gpDrive[PIN_DIV4] |=> !portPadOe_n[PIN_DIV4]
            && portPadOut[PIN_DIV4] == $past(clockOutDivFour))
        else $error("div four pin not carrying clock");
    chk_irq_input_only: assert property (
        gpDrive[PIN_EIRQ_HI:PIN_EIRQ_LO] == 4'h0
            |=> portPadOe_n[PIN_EIRQ_HI:PIN_EIRQ_LO] == 4'hf)
        else $error("interrupt pin driven without port setup");
    chk_pci_pin_none: assert property (
        (HAS_PCI && !pciActive && !portPinEnableBit[PIN_PCI_LO])
            |=> portPadOe_n[PIN_PCI_LO] && !portPinIn[PIN_PCI_LO]
                && !pciPortIn[0])
        else $error("pci shared port pin has a function");
    chk_host_default: assert property (
        !pciActive |=> hostPadOut == $past(hostPortOut) && pciHostIn == 8'h0)
        else $error("host pins not host port");
    chk_ser2_default: assert property (
        !serToPci |=> ser2PadOe_n == ~$past(serialPortTwoDrive)
            && serialPortTwoIn == $past(ser2PadIn))
        else $error("serial two pins not serial two");
    chk_ser1_default: assert property (
        !cellActive |=> ser1PadOut == $past(serialPortOneOut)
            && cellInterfaceIn == 3'h0)
        else $error("cell pins not serial one");
    chk_clk_source: assert property (
        !gpDrive[PIN_CLKS] |=> portPadOe_n[PIN_CLKS]
            && serial2ExtClockSource == $past(portPadIn[PIN_CLKS]))
        else $error("clock source pin not clock source");
    chk_ded_pins_off: assert property (
        !pciActive |=> dedPadOe_n == 2'h3 && pciDedIn == 2'h0)
        else $error("dedicated pci pins active without pci");
    chk_select_capture: assert property (
        (state == ST_LATCH) |-> s_latch_then_run
            ##0 selection == $past(strapStable, 2))
        else $error("selection not captured");
    chk_select_hold: assert property (
        (state == ST_RUN) |=> $stable(selection))
        else $error("selection changed after capture");
endmodule // ppsd_pin_sharing

/* verif/ppsd_pin_sharing_bench.sv */
`timescale 1ns/1ns
module ppsd_pin_sharing_bench;
    import ppsd_pkg::*;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk, rstn, clockOutDivFour, clockOutDivSix, hostPortDrive;
    logic pciHostDrive, serial2ExtClockSource;
    logic [STRAP_W-1:0] strapPins, selection;
    logic [PORT_W-1:0] portPinEnableBit, portPinDirectionBit, portPinOut;
    logic [PORT_W-1:0] portPinIn, portPadIn, portPadOut, portPadOe_n;
    logic [EIRQ_W-1:0] externalInterruptInputs;
    logic [PCI_GP_W-1:0] pciPortEnable, pciPortOut, pciPortDrive, pciPortIn;
    logic [HOST_W-1:0] hostPortOut, hostPortIn, pciHostOut, pciHostIn;
    logic [HOST_W-1:0] hostPadIn, hostPadOut, hostPadOe_n;
    logic [SER2_W-1:0] serialPortTwoOut, serialPortTwoDrive, serialPortTwoIn;
    logic [SER2_W-1:0] pciSerOut, pciSerDrive, pciSerIn;
    logic [SER2_W-1:0] ser2PadIn, ser2PadOut, ser2PadOe_n;
    logic [SER1_W-1:0] serialPortOneOut, serialPortOneDrive, serialPortOneIn;
    logic [SER1_W-1:0] cellInterfaceOut, cellInterfaceDrive, cellInterfaceIn;
    logic [SER1_W-1:0] ser1PadIn, ser1PadOut, ser1PadOe_n;
    logic [DED_W-1:0] pciDedOut, pciDedDrive, pciDedIn;
    logic [DED_W-1:0] dedPadIn, dedPadOut, dedPadOe_n;
    int err_count = 0;
    int comparisons = 0;

    ppsd_pin_sharing DUT (.clk(clk), .rstn(rstn), .strapPins(strapPins),
        .portPinEnableBit(portPinEnableBit),
        .portPinDirectionBit(portPinDirectionBit), .portPinOut(portPinOut),
        .portPinIn(portPinIn), .portPadIn(portPadIn), .portPadOut(portPadOut),
        .portPadOe_n(portPadOe_n), .clockOutDivFour(clockOutDivFour),
        .clockOutDivSix(clockOutDivSix),
        .serial2ExtClockSource(serial2ExtClockSource),
        .externalInterruptInputs(externalInterruptInputs),
        .pciPortEnable(pciPortEnable), .pciPortOut(pciPortOut),
        .pciPortDrive(pciPortDrive), .pciPortIn(pciPortIn),
        .hostPortOut(hostPortOut), .hostPortDrive(hostPortDrive),
        .hostPortIn(hostPortIn), .pciHostOut(pciHostOut),
        .pciHostDrive(pciHostDrive), .pciHostIn(pciHostIn),
        .hostPadIn(hostPadIn), .hostPadOut(hostPadOut),
        .hostPadOe_n(hostPadOe_n), .serialPortTwoOut(serialPortTwoOut),
        .serialPortTwoDrive(serialPortTwoDrive),
        .serialPortTwoIn(serialPortTwoIn), .pciSerOut(pciSerOut),
        .pciSerDrive(pciSerDrive), .pciSerIn(pciSerIn),
        .ser2PadIn(ser2PadIn), .ser2PadOut(ser2PadOut),
        .ser2PadOe_n(ser2PadOe_n), .serialPortOneOut(serialPortOneOut),
        .serialPortOneDrive(serialPortOneDrive),
        .serialPortOneIn(serialPortOneIn),
        .cellInterfaceOut(cellInterfaceOut),
        .cellInterfaceDrive(cellInterfaceDrive),
        .cellInterfaceIn(cellInterfaceIn), .ser1PadIn(ser1PadIn),
        .ser1PadOut(ser1PadOut), .ser1PadOe_n(ser1PadOe_n),
        .pciDedOut(pciDedOut), .pciDedDrive(pciDedDrive),
        .pciDedIn(pciDedIn), .dedPadIn(dedPadIn), .dedPadOut(dedPadOut),
        .dedPadOe_n(dedPadOe_n), .selection(selection));

    // ************************************************************
    // clock, helpers
    // ************************************************************
    always #4 clk = ~clk;

    task automatic cmp(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic do_reset(input logic [2:0] strap);
        @(posedge clk);
        rstn <= 1'b0;
        strapPins <= strap;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task automatic conclude;
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic defaults_check;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            clockOutDivFour <= i[0];
            clockOutDivSix <= ~i[0];
            settle(2);
            cmp("clock pins", 16'({clockOutDivSix, clockOutDivFour}),
                16'(portPadOut[2:1]));
            cmp("clock oe", 16'h0, 16'(portPadOe_n[2:1]));
        end
        cmp("clock source", 16'(portPadIn[8]), 16'(serial2ExtClockSource));
        cmp("pin8 oe", 16'h1, 16'(portPadOe_n[8]));
        cmp("pci pin oe", 16'h7f, 16'(portPadOe_n[15:9]));
        cmp("pci pin in", 16'h0, 16'(pciPortIn));
        cmp("port pin in", 16'h0, 16'(portPinIn[15:9]));
        cmp("irq oe", 16'hf, 16'(portPadOe_n[7:4]));
        cmp("host out", 16'(hostPortOut), 16'(hostPadOut));
        cmp("host oe", 16'h0, 16'(hostPadOe_n));
        cmp("host in", 16'(hostPadIn), 16'(hostPortIn));
        cmp("pci host in", 16'h0, 16'(pciHostIn));
        cmp("ser2 out", 16'(serialPortTwoOut), 16'(ser2PadOut));
        cmp("ser2 in", 16'(ser2PadIn), 16'(serialPortTwoIn));
        cmp("ser2 oe", 16'h1, 16'(ser2PadOe_n));
        cmp("pci ser in", 16'h0, 16'(pciSerIn));
        cmp("ser1 out", 16'(serialPortOneOut), 16'(ser1PadOut));
        cmp("ser1 in", 16'(ser1PadIn), 16'(serialPortOneIn));
        cmp("ser1 oe", 16'h2, 16'(ser1PadOe_n));
        cmp("cell in", 16'h0, 16'(cellInterfaceIn));
        cmp("ded oe", 16'h3, 16'(dedPadOe_n));
        cmp("ded in", 16'h0, 16'(pciDedIn));
    endtask

    task automatic port_takeover;
        @(posedge clk);
        portPinEnableBit <= 16'h0106;
        portPinDirectionBit <= 16'h0002;
        clockOutDivFour <= 1'b0;
        settle(2);
        cmp("pin1 port", 16'(portPinOut[1]), 16'(portPadOut[1]));
        cmp("pin2 clock", 16'(clockOutDivSix), 16'(portPadOut[2]));
        cmp("pin8 half set", 16'h1, 16'(portPadOe_n[8]));
        @(posedge clk);
        portPinEnableBit <= 16'h0306;
        portPinDirectionBit <= 16'h0306;
        settle(2);
        cmp("pins port", 16'(portPinOut[2:1]), 16'(portPadOut[2:1]));
        cmp("pin8 out", 16'(portPinOut[8]), 16'(portPadOut[8]));
        cmp("pin8 oe", 16'h0, 16'(portPadOe_n[8]));
        cmp("clock source off", 16'h0, 16'(serial2ExtClockSource));
        cmp("pin9 port oe", 16'h0, 16'(portPadOe_n[9]));
        @(posedge clk);
        portPinEnableBit <= 16'h0;
        portPinDirectionBit <= 16'h0;
        settle(2);
        cmp("clock back", 16'(clockOutDivFour), 16'(portPadOut[1]));
    endtask

    task automatic irq_inputs;
        @(posedge clk);
        portPadIn[7:4] <= 4'h9;
        settle(6);
        cmp("irq in", 16'h9, 16'(externalInterruptInputs));
        cmp("irq port in", 16'h9, 16'(portPinIn[7:4]));
        cmp("irq oe", 16'hf, 16'(portPadOe_n[7:4]));
    endtask

    task automatic strap_select;
        do_reset(3'h3);
        @(negedge clk);
        cmp("selection", 16'h3, 16'(selection));
        @(posedge clk);
        strapPins <= 3'h4;
        settle(8);
        cmp("selection held", 16'h3, 16'(selection));
        cmp("host pci out", 16'(pciHostOut), 16'(hostPadOut));
        cmp("host pci in", 16'(hostPadIn), 16'(pciHostIn));
        cmp("host port in", 16'h0, 16'(hostPortIn));
        cmp("ser2 pci out", 16'(pciSerOut), 16'(ser2PadOut));
        cmp("ser2 pci oe", 16'h0, 16'(ser2PadOe_n));
        cmp("ser2 gated", 16'h0, 16'(serialPortTwoIn));
        cmp("ser1 cell out", 16'(cellInterfaceOut), 16'(ser1PadOut));
        cmp("cell in", 16'(ser1PadIn), 16'(cellInterfaceIn));
        cmp("cell oe", 16'h0, 16'(ser1PadOe_n));
        cmp("pci pins out", 16'(pciPortOut), 16'(portPadOut[15:9]));
        cmp("pci pins in", 16'(portPadIn[15:9]), 16'(pciPortIn));
        cmp("ded out", 16'(pciDedOut), 16'(dedPadOut));
        cmp("ded oe", 16'h0, 16'(dedPadOe_n));
        cmp("ded pci in", 16'(dedPadIn), 16'(pciDedIn));
        do_reset(3'h5);
        settle(1);
        cmp("selection", 16'h5, 16'(selection));
        cmp("ser2 kept", 16'(serialPortTwoOut), 16'(ser2PadOut));
        cmp("ser1 kept", 16'(serialPortOneOut), 16'(ser1PadOut));
        cmp("ser2 kept oe", 16'h1, 16'(ser2PadOe_n));
        cmp("ser1 kept oe", 16'h2, 16'(ser1PadOe_n));
        cmp("host pci", 16'(pciHostOut), 16'(hostPadOut));
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        strapPins = 3'h0;
        portPinEnableBit = 16'h0;
        portPinDirectionBit = 16'h0;
        portPinOut = 16'h5bd6;
        portPadIn = 16'ha5c3;
        clockOutDivFour = 1'b1;
        clockOutDivSix = 1'b0;
        pciPortEnable = 7'h7f;
        pciPortOut = 7'h55;
        pciPortDrive = 7'h7f;
        hostPortOut = 8'h3c;
        hostPortDrive = 1'b1;
        pciHostOut = 8'hc3;
        pciHostDrive = 1'b1;
        hostPadIn = 8'h5a;
        serialPortTwoOut = 3'h5;
        serialPortTwoDrive = 3'h6;
        pciSerOut = 3'h2;
        pciSerDrive = 3'h7;
        ser2PadIn = 3'h6;
        serialPortOneOut = 3'h3;
        serialPortOneDrive = 3'h5;
        cellInterfaceOut = 3'h4;
        cellInterfaceDrive = 3'h7;
        ser1PadIn = 3'h1;
        pciDedOut = 2'h1;
        pciDedDrive = 2'h3;
        dedPadIn = 2'h2;
        settle(2);
        cmp("reset oe", 16'hffff, portPadOe_n);
        cmp("reset selection", 16'h0, 16'(selection));
        @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        defaults_check();
        port_takeover();
        irq_inputs();
        strap_select();
        conclude();
    end
endmodule // ppsd_pin_sharing_bench
